/* frame_classifier.v */
`timescale 1ns/1ps
`include "mac_rx_stats_consts.vh"
module frame_classifier
(
  // clock and reset
  input  wire                  clock,
  input  wire                  rst,
  // finished frame
  input  wire                  done,
  input  wire [`LEN_WIDTH-1:0] length,
  input  wire                  dribble,
  input  wire                  crc_bad,
  input  wire                  symbol_error,
  input  wire                  addr_match,
  input  wire                  no_buffer,
  input  wire                  overrun,
  // configuration
  input  wire                  big_frame_enable,
  input  wire                  jumbo_frame_enable,
  // one-cycle increment pulses
  output reg                   inc_no_buffer,
  output reg                   inc_overrun,
  output reg                   inc_symbol,
  output reg                   inc_excess,
  output reg                   inc_jabber,
  output reg                   inc_undersize,
  output reg                   inc_crc,
  output reg                   inc_align
);

  reg [`LEN_WIDTH-1:0] max_length;
  wire                 too_long;
  wire                 too_short;
  wire                 in_range;
  wire                 any_error;

  // current maximum length, jumbo over big
  always @*
  begin
    if (jumbo_frame_enable)
      max_length = `LEN_MAX_JUMBO;
    else if (big_frame_enable)
      max_length = `LEN_MAX_BIG;
    else
      max_length = `LEN_MAX_NORMAL;
  end

  // length and error classes
  assign too_long  = length > max_length;
  assign too_short = length < `LEN_MIN;
  assign in_range  = !too_long && !too_short;
  assign any_error = crc_bad || symbol_error;

  // registered increment pulses, one per frame
  always @(posedge clock)
  begin
    if (rst)
    begin
      inc_no_buffer <= 1'b0;
      inc_overrun   <= 1'b0;
      inc_symbol    <= 1'b0;
      inc_excess    <= 1'b0;
      inc_jabber    <= 1'b0;
      inc_undersize <= 1'b0;
      inc_crc       <= 1'b0;
      inc_align     <= 1'b0;
    end
    else
    begin
      inc_no_buffer <= done && addr_match && no_buffer;
      inc_overrun   <= done && addr_match && overrun;
      inc_symbol    <= done && symbol_error;
      inc_excess    <= done && too_long && !any_error;
      inc_jabber    <= done && too_long && any_error;
      inc_undersize <= done && too_short && !any_error;
      inc_crc       <= done && in_range && !dribble && any_error;
      inc_align     <= done && in_range && dribble && any_error;
    end
  end

endmodule

/* mac_rx_error_statistics.v */
// Operation
// - 16-bit count of address-matched frames dropped for lack of buffer
// - 8-bit count of address-matched frames lost to receive DMA overrun
// - 8-bit count of frames that saw the media receive-error signal
// - in-range frame with symbol error also counts as crc or alignment
// - over-length frame with symbol error also counts as jabber
// - maximum length 1518, 1536 with big bit 8, 10240 with jumbo bit 3
// - 8-bit count of over-length frames without any error
// - 8-bit count of over-length frames with crc, alignment or symbol error
// - 8-bit count of frames under 64 bytes without any error
// - 8-bit count of whole-byte in-range frames with bad crc
// - 8-bit count of odd-bit in-range frames with bad truncated crc
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "mac_rx_stats_consts.vh"
module mac_rx_error_statistics
(
  // clock and reset
  input  wire                  clock,
  input  wire                  rst,
  // register port
  input  wire [7:0]            address,
  input  wire [31:0]           write_data,
  input  wire                  write_strobe,
  input  wire                  read_strobe,
  output reg  [31:0]           read_data,
  // media pin
  input  wire                  rx_er,
  // frame status from receive logic
  input  wire                  frame_active,
  input  wire                  frame_done,
  input  wire [`LEN_WIDTH-1:0] frame_length,
  input  wire                  frame_dribble,
  input  wire                  frame_crc_bad,
  input  wire                  frame_addr_match,
  input  wire                  frame_no_buffer,
  input  wire                  frame_overrun,
  // interrupt
  output reg                   irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg [`CONFIG_WIDTH-1:0] network_config_register;
  reg [15:0]              no_buffer_drop_count;
  reg [7:0]               receive_overrun_count;
  reg [7:0]               receive_symbol_error_count;
  reg [7:0]               excessive_length_count;
  reg [7:0]               receive_jabber_count;
  reg [7:0]               undersize_frame_count;
  reg [7:0]               crc_error_count;
  reg [7:0]               alignment_error_count;
  reg [7:0]               irq_status;
  reg [7:0]               irq_enable;
  reg [7:0]               next_irq_status;
  reg [31:0]              next_read_data;
  reg                     rx_er_meta;
  reg                     rx_er_sync;
  reg                     rx_er_late;
  reg                     rx_er_level;
  reg                     symbol_seen;
  wire                    big_frame_enable;
  wire                    jumbo_frame_enable;
  wire                    frame_symbol_error;
  wire [7:0]              events;
  wire                    inc_no_buffer;
  wire                    inc_overrun;
  wire                    inc_symbol;
  wire                    inc_excess;
  wire                    inc_jabber;
  wire                    inc_undersize;
  wire                    inc_crc;
  wire                    inc_align;

  // ****************************************************************
  // helpers
  // ****************************************************************

  // next value of an 8-bit counter: write overwrites, else step by one
  function [7:0] bump8;
    input [7:0]  count;
    input        inc;
    input        wr;
    input [31:0] data;
    begin
      if (wr)
        bump8 = data[7:0];
      else if (inc)
        bump8 = count + 8'h01;
      else
        bump8 = count;
    end
  endfunction

  // write strobe decode for one offset
  function hit;
    input [7:0] addr;
    input [7:0] offset;
    input       strobe;
    begin
      hit = strobe && (addr == offset);
    end
  endfunction

  assign big_frame_enable   = network_config_register[`BIT_BIG_FRAME];
  assign jumbo_frame_enable = network_config_register[`BIT_JUMBO_FRAME];

  // ****************************************************************
  // receive-error pin synchroniser
  // ****************************************************************

  // three stages; level moves only when the last two agree
  always @(posedge clock)
  begin
    if (rst)
    begin
      rx_er_meta  <= 1'b0;
      rx_er_sync  <= 1'b0;
      rx_er_late  <= 1'b0;
      rx_er_level <= 1'b0;
    end
    else
    begin
      rx_er_meta <= rx_er;
      rx_er_sync <= rx_er_meta;
      rx_er_late <= rx_er_sync;
      if (rx_er_sync == rx_er_late)
        rx_er_level <= rx_er_late;
    end
  end

  // catch any receive error while the frame is open
  always @(posedge clock)
  begin
    if (rst)
      symbol_seen <= 1'b0;
    else if (frame_done)
      symbol_seen <= 1'b0;
    else if (frame_active && rx_er_level)
      symbol_seen <= 1'b1;
  end

  // an error seen in the closing cycle still belongs to the frame
  assign frame_symbol_error = symbol_seen || (frame_active && rx_er_level);

  // ****************************************************************
  // frame classification
  // ****************************************************************
  frame_classifier classify
  (
    .clock              (clock),
    .rst                (rst),
    .done               (frame_done),
    .length             (frame_length),
    .dribble            (frame_dribble),
    .crc_bad            (frame_crc_bad),
    .symbol_error       (frame_symbol_error),
    .addr_match         (frame_addr_match),
    .no_buffer          (frame_no_buffer),
    .overrun            (frame_overrun),
    .big_frame_enable   (big_frame_enable),
    .jumbo_frame_enable (jumbo_frame_enable),
    .inc_no_buffer      (inc_no_buffer),
    .inc_overrun        (inc_overrun),
    .inc_symbol         (inc_symbol),
    .inc_excess         (inc_excess),
    .inc_jabber         (inc_jabber),
    .inc_undersize      (inc_undersize),
    .inc_crc            (inc_crc),
    .inc_align          (inc_align)
  );

  // ****************************************************************
  // configuration and counters
  // ****************************************************************

  // configuration register
  always @(posedge clock)
  begin
    if (rst)
      network_config_register <= `CONFIG_RESET;
    else if (hit(address, `OFS_NET_CONFIG, write_strobe))
      network_config_register <= write_data[`CONFIG_WIDTH-1:0];
  end

  // wide drop counter
  always @(posedge clock)
  begin
    if (rst)
      no_buffer_drop_count <= `WIDE_COUNT_RESET;
    else if (hit(address, `OFS_NO_BUFFER_DROP, write_strobe))
      no_buffer_drop_count <= write_data[15:0];
    else if (inc_no_buffer)
      no_buffer_drop_count <= no_buffer_drop_count + 16'h0001;
  end

  // 8-bit statistics counters
  always @(posedge clock)
  begin
    if (rst)
    begin
      receive_overrun_count      <= `COUNT_RESET;
      receive_symbol_error_count <= `COUNT_RESET;
      excessive_length_count     <= `COUNT_RESET;
      receive_jabber_count       <= `COUNT_RESET;
      undersize_frame_count      <= `COUNT_RESET;
      crc_error_count            <= `COUNT_RESET;
      alignment_error_count      <= `COUNT_RESET;
    end
    else
    begin
      receive_overrun_count <= bump8(receive_overrun_count, inc_overrun,
        hit(address, `OFS_RX_OVERRUN, write_strobe), write_data);
      receive_symbol_error_count <= bump8(receive_symbol_error_count,
        inc_symbol, hit(address, `OFS_RX_SYMBOL_ERR, write_strobe),
        write_data);
      excessive_length_count <= bump8(excessive_length_count, inc_excess,
        hit(address, `OFS_EXCESS_LENGTH, write_strobe), write_data);
      receive_jabber_count <= bump8(receive_jabber_count, inc_jabber,
        hit(address, `OFS_RX_JABBER, write_strobe), write_data);
      undersize_frame_count <= bump8(undersize_frame_count, inc_undersize,
        hit(address, `OFS_UNDERSIZE, write_strobe), write_data);
      crc_error_count <= bump8(crc_error_count, inc_crc,
        hit(address, `OFS_CRC_ERROR, write_strobe), write_data);
      alignment_error_count <= bump8(alignment_error_count, inc_align,
        hit(address, `OFS_ALIGN_ERROR, write_strobe), write_data);
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  assign events = {inc_align, inc_crc, inc_undersize, inc_jabber,
                   inc_excess, inc_symbol, inc_overrun, inc_no_buffer};

  // sticky status: clear by writing ones, a new event wins
  always @*
  begin
    next_irq_status = irq_status;
    if (hit(address, `OFS_IRQ_CLEAR, write_strobe))
      next_irq_status = irq_status & ~write_data[7:0];
    next_irq_status = next_irq_status | events;
  end

  // status, enable and interrupt line
  always @(posedge clock)
  begin
    if (rst)
    begin
      irq_status <= `IRQ_RESET;
      irq_enable <= `IRQ_RESET;
      irq        <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      if (hit(address, `OFS_IRQ_ENABLE, write_strobe))
        irq_enable <= write_data[7:0];
      irq <= |(next_irq_status & irq_enable);
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************

  // read mux, unmapped and write-only offsets read zero
  always @*
  begin
    next_read_data = 32'h00000000;
    case (address)
      `OFS_NET_CONFIG:
        next_read_data[`CONFIG_WIDTH-1:0] = network_config_register;
      `OFS_NO_BUFFER_DROP:
        next_read_data[15:0] = no_buffer_drop_count;
      `OFS_RX_OVERRUN:
        next_read_data[7:0] = receive_overrun_count;
      `OFS_RX_SYMBOL_ERR:
        next_read_data[7:0] = receive_symbol_error_count;
      `OFS_EXCESS_LENGTH:
        next_read_data[7:0] = excessive_length_count;
      `OFS_RX_JABBER:
        next_read_data[7:0] = receive_jabber_count;
      `OFS_UNDERSIZE:
        next_read_data[7:0] = undersize_frame_count;
      `OFS_CRC_ERROR:
        next_read_data[7:0] = crc_error_count;
      `OFS_ALIGN_ERROR:
        next_read_data[7:0] = alignment_error_count;
      `OFS_IRQ_STATUS:
        next_read_data[7:0] = irq_status;
      `OFS_IRQ_ENABLE:
        next_read_data[7:0] = irq_enable;
      default:
        next_read_data = 32'h00000000;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always @(posedge clock)
  begin
    if (rst)
      read_data <= 32'h00000000;
    else if (read_strobe)
      read_data <= next_read_data;
    else
      read_data <= 32'h00000000;
  end

endmodule

/* mac_rx_error_statistics_asserts.sv */
`timescale 1ns/1ps
`include "mac_rx_stats_consts.vh"
// ****
// register port checker
// ****
module mac_rx_stats_checker
(
  // clock and reset
  input wire        clock,
  input wire        rst,
  // register port
  input wire [7:0]  address,
  input wire [31:0] write_data,
  input wire        write_strobe,
  input wire        read_strobe,
  input wire [31:0] read_data,
  // frame end and interrupt
  input wire        frame_done,
  input wire        frame_crc_bad,
  input wire        irq
);
  reg  [2:0] since_done;
  wire       quiet;
  // cycles since the last frame end, so pending increments are excluded
  always @(posedge clock)
  begin
    if (rst || frame_done)
      since_done <= 3'h0;
    else if (since_done != 3'h7)
      since_done <= since_done + 3'h1;
  end
  assign quiet = (since_done > 3'h3) && !frame_done;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // a write followed at once by a read returns the written bits
  property p_back(a, m);
    (write_strobe && address == a) ##1 (read_strobe && address == a && quiet)
      |=> read_data == ($past(write_data, 2) & m);
  endproperty
  a_back_wide: assert property (p_back(`OFS_NO_BUFFER_DROP, 32'h0000FFFF))
    else $error("wide counter readback wrong");
  a_back_ovr: assert property (p_back(`OFS_RX_OVERRUN, 32'h000000FF))
    else $error("overrun counter readback wrong");
  a_back_sym: assert property (p_back(`OFS_RX_SYMBOL_ERR, 32'h000000FF))
    else $error("symbol counter readback wrong");
  a_back_jab: assert property (p_back(`OFS_RX_JABBER, 32'h000000FF))
    else $error("jabber counter readback wrong");
  a_narrow_upper: assert property ($past(read_strobe) &&
    ($past(address) inside {8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20})
    |-> read_data[31:8] == 24'h000000) else $error("narrow upper bits set");
  a_wide_upper: assert property ($past(read_strobe) &&
    $past(address) == `OFS_NO_BUFFER_DROP |-> read_data[31:16] == 16'h0000)
    else $error("wide counter upper bits set");
  a_read_gap: assert property (!$past(read_strobe) |->
    read_data == 32'h00000000) else $error("read data outside slot");
  a_count_stable: assert property ((read_strobe && quiet) ##1
    (read_strobe && quiet && address == $past(address))
    |=> read_data == $past(read_data)) else $error("counter moved unasked");
  a_irq_reset: assert property (disable iff (1'b0) rst |=> !irq)
    else $error("interrupt high after reset");
  c_write_read: cover property (write_strobe ##1 read_strobe);
  c_bad_frame: cover property (frame_done && frame_crc_bad);
  c_irq: cover property ($rose(irq));
endmodule

/* mac_rx_stats_consts.vh */
`ifndef MAC_RX_STATS_CONSTS_VH
`define MAC_RX_STATS_CONSTS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_NET_CONFIG      8'h00
`define OFS_NO_BUFFER_DROP  8'h04
`define OFS_RX_OVERRUN      8'h08
`define OFS_RX_SYMBOL_ERR   8'h0C
`define OFS_EXCESS_LENGTH   8'h10
`define OFS_RX_JABBER       8'h14
`define OFS_UNDERSIZE       8'h18
`define OFS_CRC_ERROR       8'h1C
`define OFS_ALIGN_ERROR     8'h20
`define OFS_IRQ_STATUS      8'h24
`define OFS_IRQ_CLEAR       8'h28
`define OFS_IRQ_ENABLE      8'h2C

// ****************************************************************
// configuration fields and reset values
// ****************************************************************
`define BIT_JUMBO_FRAME     3
`define BIT_BIG_FRAME       8
`define CONFIG_WIDTH        9
`define CONFIG_RESET        9'h000
`define COUNT_RESET         8'h00
`define WIDE_COUNT_RESET    16'h0000
`define IRQ_RESET           8'h00

// ****************************************************************
// interrupt status bit positions
// ****************************************************************
`define IRQ_NO_BUFFER       0
`define IRQ_OVERRUN         1
`define IRQ_SYMBOL          2
`define IRQ_EXCESS          3
`define IRQ_JABBER          4
`define IRQ_UNDERSIZE       5
`define IRQ_CRC             6
`define IRQ_ALIGN           7

// ****************************************************************
// frame length limits in bytes
// ****************************************************************
`define LEN_WIDTH           14
`define LEN_MIN             14'h0040
`define LEN_MAX_NORMAL      14'h05EE
`define LEN_MAX_BIG         14'h0600
`define LEN_MAX_JUMBO       14'h2800

`endif

/* phy_model.sv */
`timescale 1ns/1ps
`include "mac_rx_stats_consts.vh"
// ****
// receive side frame source
// ****
module phy_model
(
  // clock
  input  wire                  clock,
  // media pin
  output reg                   rx_er,
  // frame status
  output reg                   frame_active,
  output reg                   frame_done,
  output reg  [`LEN_WIDTH-1:0] frame_length,
  output reg                   frame_dribble,
  output reg                   frame_crc_bad,
  output reg                   frame_addr_match,
  output reg                   frame_no_buffer,
  output reg                   frame_overrun
);
  // status lines; f is dribble crc symbol match nobuffer overrun
  task put(input [13:0] len, input [5:0] f);
    begin
      frame_length <= len;
      {frame_dribble, frame_crc_bad} <= f[5:4];
      {frame_addr_match, frame_no_buffer, frame_overrun} <= f[2:0];
    end
  endtask
  // idle line levels
  initial
  begin
    rx_er = 1'b0;
    frame_active = 1'b0;
    frame_done = 1'b0;
    put(14'h2AAA, 6'h15);
  end
  // nine receive cycles, status valid beside the done pulse
  task send(input [13:0] len, input [5:0] f);
    integer n;
    begin
      for (n = 0; n < 9; n = n + 1)
      begin
        @(posedge clock);
        frame_active <= 1'b1;
        rx_er <= f[3];
        frame_done <= (n == 8);
      end
      put(len, f);
      @(posedge clock);
      frame_active <= 1'b0;
      rx_er <= 1'b0;
      frame_done <= 1'b0;
      put(~len, ~f); // released status shows the inverse
    end
  endtask
endmodule

/* tb_mac_rx_error_statistics.sv */
`timescale 1ns/1ps
`include "mac_rx_stats_consts.vh"
// ****
// bench for the receive statistics block
// ****
module tb_mac_rx_error_statistics;
  reg         clock, rst, write_strobe, read_strobe;
  reg  [7:0]  address, sts, en;
  reg  [31:0] write_data, v;
  reg  [15:0] e [0:7];
  reg  [13:0] cur_max, len;
  wire [31:0] read_data;
  wire        irq, rx_er, frame_active, frame_done, frame_dribble;
  wire        frame_crc_bad, frame_addr_match, frame_no_buffer, frame_overrun;
  wire [`LEN_WIDTH-1:0] frame_length;
  integer     n_fail, checks_done, i, k, md;
  // block under test and its frame source
  mac_rx_error_statistics mac_rx_error_statistics_i (.clock(clock),
    .rst(rst), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .rx_er(rx_er), .frame_active(frame_active),
    .frame_done(frame_done), .frame_length(frame_length),
    .frame_dribble(frame_dribble), .frame_crc_bad(frame_crc_bad),
    .frame_addr_match(frame_addr_match), .frame_no_buffer(frame_no_buffer),
    .frame_overrun(frame_overrun), .irq(irq));
  phy_model phy_model_i (.clock(clock), .rx_er(rx_er),
    .frame_active(frame_active), .frame_done(frame_done),
    .frame_length(frame_length), .frame_dribble(frame_dribble),
    .frame_crc_bad(frame_crc_bad), .frame_addr_match(frame_addr_match),
    .frame_no_buffer(frame_no_buffer), .frame_overrun(frame_overrun));
  // clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        n_fail = n_fail + 1;
        $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      write_strobe <= 1'b1;
      address <= a;
      write_data <= d;
      @(posedge clock);
      write_strobe <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      read_strobe <= 1'b1;
      address <= a;
      @(posedge clock);
      read_strobe <= 1'b0;
      // data stand for one cycle only, look mid-cycle
      @(negedge clock);
      d = read_data;
      @(posedge clock);
    end
  endtask
  task clear_model;
    begin
      for (i = 0; i < 8; i = i + 1)
        e[i] = 16'h0000;
      sts = 8'h00;
      en = 8'h00;
      cur_max = 14'h05EE;
    end
  endtask
  task check_all;
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        rd(8'h04 + {i[5:0], 2'b00}, v);
        if (i < 3)
          chk(v, {16'h0000, e[i]});
        else
          chk(v, {16'h0000, e[i]});
      end
      rd(`OFS_IRQ_STATUS, v);
      chk(v, {24'h000000, sts});
      chk({31'h00000000, irq}, {31'h00000000, |(sts & en)});
    end
  endtask
  task bump(input integer b);
    begin
      e[b] = (b == 0) ? e[b] + 16'h0001 : {8'h00, e[b][7:0] + 8'h01};
      sts[b] = 1'b1;
    end
  endtask
  // f is dribble crc symbol match nobuffer overrun
  task frame(input [13:0] ln, input [5:0] f);
    begin
      if (f[2] & f[1])
        bump(0);
      if (f[2] & f[0])
        bump(1);
      if (f[3])
        bump(2);
      if (ln > cur_max)
        bump((f[4] | f[3]) ? 4 : 3);
      else if (ln < 14'h0040 && !(f[4] | f[3]))
        bump(5);
      else if (ln >= 14'h0040 && (f[4] | f[3]))
        bump(f[5] ? 7 : 6);
      phy_model_i.send(ln, f);
      repeat (3) @(posedge clock);
      check_all;
    end
  endtask
  task t_reset;
    begin
      check_all;
      rd(`OFS_NET_CONFIG, v);
      chk(v, 32'h00000000);
      rd(8'h30, v);
      chk(v, 32'h00000000);
      rd(`OFS_IRQ_CLEAR, v);
      chk(v, 32'h00000000);
    end
  endtask
  // every length limit, at its boundaries, clean and with each error
  task t_lengths;
    begin
      for (md = 0; md < 4; md = md + 1)
      begin
        wr(`OFS_NET_CONFIG, {23'h000000, md[0], 4'h0, md[1], 3'h0});
        cur_max = md[1] ? 14'h2800 : (md[0] ? 14'h0600 : 14'h05EE);
        rd(`OFS_NET_CONFIG, v);
        chk(v, {23'h000000, md[0], 4'h0, md[1], 3'h0});
        for (k = 0; k < 12; k = k + 1)
        begin
          len = (k < 3) ? 14'h003F : (k < 6) ? 14'h0040 :
            cur_max + k[13:0] / 14'h0003 - 14'h0002;
          frame(len, {k[0], k % 3 == 1, k % 3 == 2, 3'b100});
        end
      end
    end
  endtask
  task t_drops;
    begin
      frame(14'h0100, 6'b000011);
      frame(14'h0100, 6'b000110);
      frame(14'h0100, 6'b000101);
    end
  endtask
  // full scale writes read back at once, then each counter wraps
  task t_write;
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        wr(8'h04 + {i[5:0], 2'b00}, 32'hFFFFFFFF);
        rd(8'h04 + {i[5:0], 2'b00}, v);
        e[i] = (i == 0) ? 16'hFFFF : 16'h00FF;
        chk(v, {16'h0000, e[i]});
      end
      wr(`OFS_IRQ_STATUS, 32'h00000000);
      frame(14'h3000, 6'b011111);
      frame(14'h3000, 6'b000100);
      frame(14'h0020, 6'b000100);
      frame(14'h0100, 6'b110100);
      frame(14'h0100, 6'b010100);
      // two reads with no gap must return the same count
      read_strobe <= 1'b1;
      address <= `OFS_RX_JABBER;
      @(posedge clock);
      @(negedge clock);
      v = read_data;
      chk(v, {16'h0000, e[4]});
      @(posedge clock);
      read_strobe <= 1'b0;
      @(negedge clock);
      v = read_data;
      chk(v, {16'h0000, e[4]});
      @(posedge clock);
    end
  endtask
  task t_irq;
    begin
      wr(`OFS_IRQ_CLEAR, 32'h000000FF);
      sts = 8'h00;
      @(posedge clock);
      wr(`OFS_IRQ_ENABLE, 32'h00000010);
      en = 8'h10;
      rd(`OFS_IRQ_ENABLE, v);
      chk(v, 32'h00000010);
      frame(14'h3000, 6'b010100);
      frame(14'h0020, 6'b000100);
      wr(`OFS_IRQ_CLEAR, 32'h00000010);
      sts[4] = 1'b0;
      check_all;
    end
  endtask
  task t_midreset;
    begin
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      clear_model;
      check_all;
    end
  endtask
  // reset, then the scenarios
  initial
  begin
    n_fail = 0;
    checks_done = 0;
    rst = 1'b1;
    address = 8'h00;
    write_data = 32'h00000000;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    clear_model;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset;
    t_lengths;
    t_drops;
    t_write;
    t_irq;
    t_midreset;
    test_done;
  end
  // watchdog
  initial
  begin
    #400000;
    n_fail = n_fail + 1;
    test_done;
  end
endmodule
bind mac_rx_error_statistics mac_rx_stats_checker mac_rx_stats_checker_i (
  .clock(clock), .rst(rst), .address(address), .write_data(write_data),
  .write_strobe(write_strobe), .read_strobe(read_strobe),
  .read_data(read_data), .frame_done(frame_done),
  .frame_crc_bad(frame_crc_bad), .irq(irq));
